// >>> verilog/ptsc_top.v
// Pixel tone and sharpening stage: gain, black level, white balance, gamma, sharpening.
// Assumes an APB master for settings and a Bayer pixel stream with frame start strobes.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "ptsc_defs.vh"
// Functional notes
// - Sharpening off after reset; off passes pixels.
// - Auto threshold derived from measured noise.
// - Correction proportional to neighbour difference.
// - Negative smooths, positive boosts, zero unchanged.
// - Amount clamped between minus one and eight.
// - Sharpening amount resets to 2.0.
// - Sharpen only above gradient threshold.
// - Threshold is fraction of range, 0 to 0.25.
// - Thresholds above quarter act as quarter; the automatic threshold from measured noise is used unclamped.
// - Gain selector only All, gain in dB.
// - Auto gain Off, Once then Off, Continuous.
// - Black select All writable; others read-only.
// - Offset shown as percent and raw.
// - Clamping compensates sensor dark current.
// - Separate red and blue ratios via selector.
// - White balance Off manual, Once/Continuous automatic.
// - Gamma applied only when enabled.
// - Gamma off gives linear pixels.
// - Gamma precedes lookup table output.
// - Unity ratios leave colours unaltered.
module ptsc_top
#(
  parameter PIX_W = `PTSC_PIX_W
)
(
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              pix_valid,
  input  wire              pix_sof,
  input  wire [1:0]        pix_colour,
  input  wire [PIX_W-1:0]  pix_data,
  output reg               out_valid,
  output reg  [PIX_W-1:0]  out_data
);

  // ==========================================================================
  // Software-side settings.
  reg [1:0]        gsel_reg;
  reg [1:0]        ag_mode_reg;
  reg [1:0]        wb_mode_reg;
  reg [1:0]        bsel_reg;
  reg              rsel_reg;
  reg              gamma_on_reg;
  reg              sharp_on_reg;
  reg              thr_auto_reg;
  reg              dark_on_reg;
  reg [7:0]        gain_db_reg;
  reg [PIX_W-1:0]  blk_all_reg;
  reg [11:0]       ratio_r_reg;
  reg [11:0]       ratio_b_reg;
  reg [7:0]        gamma_reg;
  reg [7:0]        amt_reg;
  reg [PIX_W-1:0]  thr_reg;
  // Frame-latched shadows.
  reg              f_gamma_on_reg;
  reg              f_sharp_on_reg;
  reg              f_dark_on_reg;
  reg [7:0]        f_gain_reg;
  reg [PIX_W-1:0]  f_blk_reg;
  reg [11:0]       f_rr_reg;
  reg [11:0]       f_rb_reg;
  reg [7:0]        f_amt_reg;
  reg [PIX_W-1:0]  f_thr_reg;
  // Automatic loops and measurements.
  reg [7:0]        auto_gain_reg;
  reg [11:0]       auto_rr_reg;
  reg [11:0]       auto_rb_reg;
  reg [PIX_W-1:0]  noise_reg;
  reg [PIX_W-1:0]  dark_reg;
  reg [PIX_W-1:0]  max_reg;
  reg [PIX_W+5:0]  sum_r_reg;
  reg [PIX_W+5:0]  sum_g_reg;
  reg [PIX_W+5:0]  sum_b_reg;
  reg [PIX_W-1:0]  last_reg;

  wire             wr_acc;
  wire             rd_acc;
  wire [5:0]       addr;
  wire [PIX_W-1:0] thr_clip;
  wire [PIX_W-1:0] blk_sel;
  wire [PIX_W-1:0] gm_q;

  assign addr    = paddr[5:0];
  assign wr_acc  = psel & penable & pwrite & pready;
  assign rd_acc  = psel & ~penable & ~pwrite;
  // Threshold is in pixel units; full range is 1024, so a quarter is 256.
  assign thr_clip = (pwdata[PIX_W-1:0] > `PTSC_THR_MAX) ? `PTSC_THR_MAX
                                                        : pwdata[PIX_W-1:0];
  assign blk_sel = (bsel_reg == `PTSC_BSEL_ANALOG) ? `PTSC_BLK_ANALOG :
                   (bsel_reg == `PTSC_BSEL_DIGITAL) ? dark_reg : blk_all_reg;

  // ==========================================================================
  // APB write path.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gsel_reg     <= `PTSC_GSEL_ALL;
      ag_mode_reg  <= `PTSC_MODE_OFF;
      wb_mode_reg  <= `PTSC_MODE_OFF;
      bsel_reg     <= `PTSC_BSEL_ALL;
      rsel_reg     <= `PTSC_RSEL_RED;
      gamma_on_reg <= 1'b0;
      sharp_on_reg <= 1'b0;
      thr_auto_reg <= 1'b0;
      dark_on_reg  <= 1'b0;
      gain_db_reg  <= `PTSC_GAIN_RST;
      blk_all_reg  <= `PTSC_BLK_RST;
      ratio_r_reg  <= `PTSC_RATIO_ONE;
      ratio_b_reg  <= `PTSC_RATIO_ONE;
      gamma_reg    <= `PTSC_GAMMA_RST;
      amt_reg      <= `PTSC_AMT_RST;
      thr_reg      <= `PTSC_THR_RST;
    end
    else
    begin
      if (wr_acc && addr == `PTSC_OFF_CTRL)
      begin
        gamma_on_reg <= pwdata[`PTSC_CTRL_GAMMA_ON];
        sharp_on_reg <= pwdata[`PTSC_CTRL_SHARP_ON];
        thr_auto_reg <= pwdata[`PTSC_CTRL_THR_AUTO];
        dark_on_reg  <= pwdata[`PTSC_CTRL_DARK_ON];
        gsel_reg     <= `PTSC_GSEL_ALL;
        ag_mode_reg  <= pwdata[`PTSC_CTRL_AG_LSB+1:`PTSC_CTRL_AG_LSB];
        wb_mode_reg  <= pwdata[`PTSC_CTRL_WB_LSB+1:`PTSC_CTRL_WB_LSB];
        bsel_reg     <= pwdata[`PTSC_CTRL_BSEL_LSB+1:`PTSC_CTRL_BSEL_LSB];
        rsel_reg     <= pwdata[`PTSC_CTRL_RSEL];
      end
      else
      begin
        if (pix_sof && ag_mode_reg == `PTSC_MODE_ONCE)
          ag_mode_reg <= `PTSC_MODE_OFF;
        if (pix_sof && wb_mode_reg == `PTSC_MODE_ONCE)
          wb_mode_reg <= `PTSC_MODE_OFF;
      end
      if (wr_acc && addr == `PTSC_OFF_GAIN)
        gain_db_reg <= pwdata[7:0];
      else if (pix_sof && ag_mode_reg != `PTSC_MODE_OFF)
        gain_db_reg <= auto_gain_reg;
      if (wr_acc && addr == `PTSC_OFF_BLACK && bsel_reg == `PTSC_BSEL_ALL)
        blk_all_reg <= pwdata[PIX_W-1:0];
      if (wr_acc && addr == `PTSC_OFF_RATIO && rsel_reg == `PTSC_RSEL_RED)
        ratio_r_reg <= pwdata[11:0];
      else if (pix_sof && wb_mode_reg != `PTSC_MODE_OFF)
        ratio_r_reg <= auto_rr_reg;
      if (wr_acc && addr == `PTSC_OFF_RATIO && rsel_reg == `PTSC_RSEL_BLUE)
        ratio_b_reg <= pwdata[11:0];
      else if (pix_sof && wb_mode_reg != `PTSC_MODE_OFF)
        ratio_b_reg <= auto_rb_reg;
      if (wr_acc && addr == `PTSC_OFF_GAMMA)
        gamma_reg <= pwdata[7:0];
      if (wr_acc && addr == `PTSC_OFF_SHARP)
      begin
        amt_reg <= ($signed(pwdata[7:0]) < $signed(`PTSC_AMT_MIN)) ? `PTSC_AMT_MIN
                                                                    : pwdata[7:0];
        thr_reg <= (pwdata[31:PIX_W+16] != 6'h00) ? `PTSC_THR_MAX
                                                   : thr_clip_hi(pwdata[PIX_W+15:16]);
      end
    end
  end

  function [PIX_W-1:0] thr_clip_hi;
    input [PIX_W-1:0] v;
    begin
      thr_clip_hi = (v > `PTSC_THR_MAX) ? `PTSC_THR_MAX : v;
    end
  endfunction

  // ==========================================================================
  // APB read path; zero wait states, offsets above 0x1c read zero with an error.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (addr > `PTSC_OFF_GAMMA_TBL);
      if (rd_acc)
      begin
        case (addr)
          `PTSC_OFF_CTRL:
            prdata <= {17'h00000, rsel_reg, bsel_reg, wb_mode_reg, ag_mode_reg,
                       2'b00, gsel_reg, dark_on_reg, thr_auto_reg, sharp_on_reg,
                       gamma_on_reg};
          `PTSC_OFF_GAIN:
            prdata <= {24'h000000, gain_db_reg};
          `PTSC_OFF_BLACK:
            prdata <= {5'h00, pct(blk_sel), 6'h00, blk_sel};
          `PTSC_OFF_RATIO:
            prdata <= {20'h00000, rsel_reg ? ratio_b_reg : ratio_r_reg};
          `PTSC_OFF_GAMMA:
            prdata <= {24'h000000, gamma_reg};
          `PTSC_OFF_SHARP:
            prdata <= {6'h00, thr_auto_reg ? noise_reg : thr_reg, 8'h00, amt_reg};
          `PTSC_OFF_STATUS:
            prdata <= {6'h00, noise_reg, 6'h00, dark_reg};
          default:
            prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Percent of full range, 0..99, approximated as raw*100/1024.
  function [10:0] pct;
    input [PIX_W-1:0] v;
    reg   [PIX_W+6:0] p;
    begin
      p   = {7'h00, v} * 17'd100;
      pct = {4'h0, p[PIX_W+6:PIX_W]};
    end
  endfunction

  // ==========================================================================
  // Frame boundary latch and frame statistics.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      f_gamma_on_reg <= 1'b0;
      f_sharp_on_reg <= 1'b0;
      f_dark_on_reg  <= 1'b0;
      f_gain_reg     <= `PTSC_GAIN_RST;
      f_blk_reg      <= `PTSC_BLK_RST;
      f_rr_reg       <= `PTSC_RATIO_ONE;
      f_rb_reg       <= `PTSC_RATIO_ONE;
      f_amt_reg      <= `PTSC_AMT_RST;
      f_thr_reg      <= `PTSC_THR_RST;
      auto_gain_reg  <= `PTSC_GAIN_RST;
      auto_rr_reg    <= `PTSC_RATIO_ONE;
      auto_rb_reg    <= `PTSC_RATIO_ONE;
      noise_reg      <= `PTSC_NOISE_MIN;
      dark_reg       <= `PTSC_BLK_RST;
      max_reg        <= {PIX_W{1'b0}};
      sum_r_reg      <= {(PIX_W+6){1'b0}};
      sum_g_reg      <= {(PIX_W+6){1'b0}};
      sum_b_reg      <= {(PIX_W+6){1'b0}};
      last_reg       <= {PIX_W{1'b0}};
    end
    else if (pix_sof)
    begin
      f_gamma_on_reg <= gamma_on_reg;
      f_sharp_on_reg <= sharp_on_reg;
      f_dark_on_reg  <= dark_on_reg;
      f_gain_reg     <= gain_db_reg;
      f_blk_reg      <= blk_all_reg;
      f_rr_reg       <= ratio_r_reg;
      f_rb_reg       <= ratio_b_reg;
      f_amt_reg      <= amt_reg;
      f_thr_reg      <= thr_auto_reg ? noise_reg : thr_reg;
      // Gain steps up while the peak is below half range and down when it reaches three quarters of full range.
      if (max_reg[PIX_W-1:PIX_W-2] == 2'b11 && auto_gain_reg != 8'h00)
        auto_gain_reg <= auto_gain_reg - 8'h01;
      else if (max_reg[PIX_W-1] == 1'b0 && auto_gain_reg != 8'hff)
        auto_gain_reg <= auto_gain_reg + 8'h01;
      // Ratios nudge red and blue sums toward the green sum.
      auto_rr_reg <= (sum_r_reg < sum_g_reg) ? auto_rr_reg + 12'h001 :
                     (sum_r_reg > sum_g_reg) ? auto_rr_reg - 12'h001 : auto_rr_reg;
      auto_rb_reg <= (sum_b_reg < sum_g_reg) ? auto_rb_reg + 12'h001 :
                     (sum_b_reg > sum_g_reg) ? auto_rb_reg - 12'h001 : auto_rb_reg;
      max_reg   <= {PIX_W{1'b0}};
      sum_r_reg <= {(PIX_W+6){1'b0}};
      sum_g_reg <= {(PIX_W+6){1'b0}};
      sum_b_reg <= {(PIX_W+6){1'b0}};
    end
    else if (pix_valid)
    begin
      last_reg <= pix_data;
      if (pix_data > max_reg)
        max_reg <= pix_data;
      // Running estimates of noise floor and dark level.
      if (absd(pix_data, last_reg) > noise_reg)
        noise_reg <= noise_reg + 10'h001;
      else if (noise_reg > `PTSC_NOISE_MIN)
        noise_reg <= noise_reg - 10'h001;
      if (pix_data < dark_reg || dark_reg == 10'h000)
        dark_reg <= pix_data;
      case (pix_colour)
        2'h0:    sum_r_reg <= sum_r_reg + {6'h00, pix_data[PIX_W-1:0]} ;
        2'h3:    sum_b_reg <= sum_b_reg + {6'h00, pix_data};
        default: sum_g_reg <= sum_g_reg + {7'h00, pix_data[PIX_W-1:1]};
      endcase
    end
  end

  function [PIX_W-1:0] absd;
    input [PIX_W-1:0] a;
    input [PIX_W-1:0] b;
    begin
      absd = (a > b) ? a - b : b - a;
    end
  endfunction

  // ==========================================================================
  // Pixel path stage 1: black level, gain, white balance.
  reg  [PIX_W-1:0] s1_reg;
  reg  [PIX_W-1:0] s1_prev_reg;
  reg  [PIX_W-1:0] s1_prev2_reg;
  reg  [3:0]       vld_reg;
  reg  [PIX_W-1:0] blk_eff;
  reg  [PIX_W-1:0] sub;
  reg  [PIX_W+11:0] bal;
  reg  [PIX_W+11:0] amp;
  wire [PIX_W-1:0] sh_out;

  always @*
  begin
    blk_eff = f_dark_on_reg ? dark_reg : f_blk_reg;
    sub     = (pix_data > blk_eff) ? pix_data - blk_eff : {PIX_W{1'b0}};
    // Gain doubles for every 8 steps (shift by bits 7:3); the low three bits have no effect.
    amp     = ({12'h000, sub} << f_gain_reg[7:3]) >> 0;
    bal     = (pix_colour == 2'h0) ? ((amp * f_rr_reg) >> 8) :
              (pix_colour == 2'h3) ? ((amp * f_rb_reg) >> 8) : amp;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg       <= {PIX_W{1'b0}};
      s1_prev_reg  <= {PIX_W{1'b0}};
      s1_prev2_reg <= {PIX_W{1'b0}};
      vld_reg      <= 4'h0;
      out_valid    <= 1'b0;
      out_data     <= {PIX_W{1'b0}};
    end
    else
    begin
      vld_reg <= {vld_reg[2:0], pix_valid};
      if (pix_valid)
      begin
        s1_reg       <= (bal > {12'h000, {PIX_W{1'b1}}}) ? {PIX_W{1'b1}} : bal[PIX_W-1:0];
        s1_prev_reg  <= s1_reg;
        s1_prev2_reg <= s1_prev_reg;
      end
      out_valid <= vld_reg[3];
      // Gamma table result replaces the sharpened pixel when gamma is on.
      if (vld_reg[3])
        out_data <= f_gamma_on_reg ? gm_q : sh_out;
    end
  end

  ptsc_sharpen #(.PIX_W(PIX_W)) u_sharp
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .en       (f_sharp_on_reg),
    .amount   (f_amt_reg),
    .thresh   (f_thr_reg),
    .prev_pix (s1_prev2_reg),
    .cur_pix  (s1_prev_reg),
    .next_pix (s1_reg),
    .out_pix  (sh_out)
  );

  ptsc_gamma_mem #(.DEPTH_W(6), .DATA_W(PIX_W)) u_gamma
  (
    .pclk    (pclk),
    .wr_en   (wr_acc && addr == `PTSC_OFF_GAMMA_TBL),
    .wr_addr (pwdata[21:16]),
    .wr_data (pwdata[PIX_W-1:0]),
    .rd_addr (sh_out[PIX_W-1:PIX_W-6]),
    .rd_data (gm_q)
  );

endmodule

// >>> include/ptsc_defs.vh
// Register map, field layouts, reset values and fixed-point formats of the pixel tone block.
// Assumes one APB slave with 32-bit data and word-aligned registers.
`ifndef PTSC_DEFS_VH
`define PTSC_DEFS_VH

`define PTSC_PIX_W          10
`define PTSC_ADDR_W         6

`define PTSC_OFF_CTRL       6'h00
`define PTSC_OFF_GAIN       6'h04
`define PTSC_OFF_BLACK      6'h08
`define PTSC_OFF_RATIO      6'h0c
`define PTSC_OFF_GAMMA      6'h10
`define PTSC_OFF_SHARP      6'h14
`define PTSC_OFF_STATUS     6'h18
`define PTSC_OFF_GAMMA_TBL  6'h1c

`define PTSC_CTRL_GAMMA_ON  0
`define PTSC_CTRL_SHARP_ON  1
`define PTSC_CTRL_THR_AUTO  2
`define PTSC_CTRL_DARK_ON   3
`define PTSC_CTRL_GSEL_LSB  4
`define PTSC_CTRL_AG_LSB    8
`define PTSC_CTRL_WB_LSB    10
`define PTSC_CTRL_BSEL_LSB  12
`define PTSC_CTRL_RSEL      14

`define PTSC_MODE_OFF       2'h0
`define PTSC_MODE_ONCE      2'h1
`define PTSC_MODE_CONT      2'h2

`define PTSC_BSEL_ALL       2'h0
`define PTSC_BSEL_ANALOG    2'h1
`define PTSC_BSEL_DIGITAL   2'h2
`define PTSC_GSEL_ALL       2'h0
`define PTSC_RSEL_RED       1'b0
`define PTSC_RSEL_BLUE      1'b1

`define PTSC_GAIN_RST       8'h00
`define PTSC_RATIO_ONE      12'h100
`define PTSC_AMT_RST        8'h20
`define PTSC_AMT_MAX        8'h7f
`define PTSC_AMT_MIN        8'hf0
`define PTSC_THR_MAX        10'h100
`define PTSC_THR_RST        10'h020
`define PTSC_BLK_RST        10'h000
`define PTSC_BLK_ANALOG     10'h010
`define PTSC_GAMMA_RST      8'h10
`define PTSC_NOISE_MIN      10'h004

`endif

// >>> verilog/ptsc_gamma_mem.v
// Gamma lookup memory: 64 entries written by software, read per pixel.
// Assumes writes come from the register slave; read data leave a register.
`timescale 1ns/10ps
module ptsc_gamma_mem
#(
  parameter DEPTH_W = 6,
  parameter DATA_W  = 10
)
(
  input  wire               pclk,
  input  wire               wr_en,
  input  wire [DEPTH_W-1:0] wr_addr,
  input  wire [DATA_W-1:0]  wr_data,
  input  wire [DEPTH_W-1:0] rd_addr,
  output reg  [DATA_W-1:0]  rd_data
);

  reg [DATA_W-1:0] mem [0:(1<<DEPTH_W)-1];

  // ==========================================================================
  // Storage.
  always @(posedge pclk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end

endmodule

// >>> verilog/ptsc_sharpen.v
// Edge sharpening for one pixel against the mean of its two row neighbours.
// Assumes amount in signed 4.4 fixed point and threshold in pixel units.
`timescale 1ns/10ps
`include "ptsc_defs.vh"
module ptsc_sharpen
#(
  parameter PIX_W = 10
)
(
  input  wire              pclk,
  input  wire              presetn,
  input  wire              en,
  input  wire [7:0]        amount,
  input  wire [PIX_W-1:0]  thresh,
  input  wire [PIX_W-1:0]  prev_pix,
  input  wire [PIX_W-1:0]  cur_pix,
  input  wire [PIX_W-1:0]  next_pix,
  output reg  [PIX_W-1:0]  out_pix
);

  wire signed [PIX_W+1:0]  mean_s;
  wire signed [PIX_W+1:0]  diff_s;
  wire        [PIX_W+1:0]  diff_abs;
  wire signed [7:0]        amt_c;
  wire signed [PIX_W+9:0]  corr;
  wire signed [PIX_W+9:0]  sum;
  reg         [PIX_W-1:0]  res;

  assign mean_s   = $signed({1'b0, (({1'b0, prev_pix} + {1'b0, next_pix}) >> 1)});
  assign diff_s   = $signed({2'b00, cur_pix}) - mean_s;
  assign diff_abs = diff_s[PIX_W+1] ? (~diff_s + 1'b1) : diff_s;
  // Amount is held to the range from minus one to 127/16, just under plus eight.
  assign amt_c    = ($signed(amount) > $signed(`PTSC_AMT_MAX)) ? $signed(`PTSC_AMT_MAX) :
                    ($signed(amount) < $signed(`PTSC_AMT_MIN)) ? $signed(`PTSC_AMT_MIN) :
                    $signed(amount);
  // Correction is the amount times the difference to the neighbours.
  assign corr     = (diff_s * amt_c) >>> 4;
  assign sum      = $signed({10'h000, cur_pix}) + corr;

  // ==========================================================================
  // Result.
  always @*
  begin
    if (!en || diff_abs <= {2'b00, thresh})
      res = cur_pix;
    else if (sum < 0)
      res = {PIX_W{1'b0}};
    else if (sum > $signed({10'h000, {PIX_W{1'b1}}}))
      res = {PIX_W{1'b1}};
    else
      res = sum[PIX_W-1:0];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_pix <= {PIX_W{1'b0}};
    else
      out_pix <= res;
  end

endmodule

// >>> testbench/ptsc_top_sva.sv
// Port checker for the pixel tone and sharpening block.
// Assumes binding to ptsc_top; one clock, asynchronous active-low reset.
`timescale 1ns/10ps
module ptsc_top_sva
#(
  parameter PIX_W = 10
)
(
  input wire             pclk,
  input wire             presetn,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [31:0]      paddr,
  input wire [31:0]      pwdata,
  input wire [31:0]      prdata,
  input wire             pready,
  input wire             pslverr,
  input wire             pix_valid,
  input wire             pix_sof,
  input wire [1:0]       pix_colour,
  input wire [PIX_W-1:0] pix_data,
  input wire             out_valid,
  input wire [PIX_W-1:0] out_data
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ======================================
  // Bus and stream relations.
  chk_bus_answer: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_phase: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  chk_err_unmapped: assert property (pready && paddr > 32'h1c |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pslverr |-> pready && paddr > 32'h1c)
    else $error("mapped access refused");
  chk_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_out_latency: assert property (pix_valid |-> ##5 out_valid)
    else $error("pixel lost in pipeline");
  chk_out_cause: assert property (out_valid |-> $past(pix_valid, 5))
    else $error("output without input pixel");
  chk_data_hold: assert property ($changed(out_data) |-> out_valid)
    else $error("pixel output changed without strobe");
  chk_reset_quiet: assert property (!$past(presetn) |-> !out_valid && !pready)
    else $error("output active after reset");
  cover property (pslverr);
  cover property (pix_valid ##5 out_valid);
  cover property (pready && pwrite);
endmodule

bind ptsc_top ptsc_top_sva #(.PIX_W(PIX_W)) i_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid),
  .pix_sof(pix_sof), .pix_colour(pix_colour), .pix_data(pix_data),
  .out_valid(out_valid), .out_data(out_data));

// >>> testbench/ptsc_pix_src.sv
// Sensor readout model: frame start pulses and pixel strobes.
// Assumes the caller starts each task just after a rising clock edge.
`timescale 1ns/10ps
module ptsc_pix_src
#(
  parameter PIX_W = 10
)
(
  input  wire              pclk,
  output logic             pix_valid,
  output logic             pix_sof,
  output logic [1:0]       pix_colour,
  output logic [PIX_W-1:0] pix_data
);
  // ======================================
  // Stimulus tasks.
  initial
  begin
    pix_valid = 1'b0;
    pix_sof = 1'b0;
    pix_colour = 2'h1;
    pix_data = '0;
  end

  task automatic frame_start();
    @(posedge pclk);
    pix_sof <= 1'b1;
    @(posedge pclk);
    pix_sof <= 1'b0;
  endtask

  // Data is inverted between strobes so no stale value looks valid.
  task automatic send(input logic [PIX_W-1:0] v, input int n, input int gap,
                      input logic [1:0] c);
    repeat (n)
    begin
      @(posedge pclk);
      pix_valid <= 1'b1;
      pix_data <= v;
      pix_colour <= c;
      @(posedge pclk);
      pix_valid <= 1'b0;
      pix_data <= ~v;
      repeat (gap) @(posedge pclk);
    end
  endtask
endmodule

// >>> testbench/tb_pixel_tone_sharpen_controls.sv
// Self-checking bench: APB settings and pixel frames through ptsc_top.
// Assumes the sensor model ptsc_pix_src and the bound port checker.
`timescale 1ns/10ps
`include "ptsc_defs.vh"
module tb_pixel_tone_sharpen_controls;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  wire         pix_valid, pix_sof, out_valid;
  wire [1:0]   pix_colour;
  wire [9:0]   pix_data, out_data;
  logic [9:0]  omax, omin;
  int          mismatches, cmp_count, cycles, ocnt;

  ptsc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_colour(pix_colour),
    .pix_data(pix_data), .out_valid(out_valid), .out_data(out_data));
  ptsc_pix_src i_src (.pclk(pclk), .pix_valid(pix_valid), .pix_sof(pix_sof),
    .pix_colour(pix_colour), .pix_data(pix_data));

  // ======================================
  // Clock, timeout and output monitor.
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      finish_test();
    end
    if (out_valid === 1'b1)
    begin
      ocnt++;
      if (out_data > omax) omax = out_data;
      if (out_data < omin) omin = out_data;
    end
  end

  // ======================================
  // Tasks.
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request is held until the rising edge at which ready is seen high.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask

  // Low, high, low runs; the middle run arrives slowly.
  task automatic frame(input logic [1:0] c, input bit midw);
    omax = 10'h000;
    omin = 10'h3ff;
    ocnt = 0;
    i_src.frame_start();
    if (midw) wr(`PTSC_OFF_SHARP, 32'h0020_0000);
    i_src.send(10'h100, 4, 0, c);
    i_src.send(10'h200, 4, 1, c);
    i_src.send(10'h100, 4, 0, c);
    repeat (12) @(posedge pclk);
  endtask

  // ======================================
  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`PTSC_OFF_CTRL, 32'h7fff, 32'h0);
    rdchk(`PTSC_OFF_SHARP, 32'h03ff_00ff, 32'h0020_0020);
    rdchk(`PTSC_OFF_RATIO, 32'hfff, 32'h100);
    rdchk(32'h20, 32'hffff_ffff, 32'h0);
    check(err, 1'b1);
    frame(2'h1, 1'b0);
    check(ocnt, 12);
    check({omax, omin}, {10'h200, 10'h100});
    frame(2'h0, 1'b0);
    check({omax, omin}, {10'h200, 10'h100});
    wr(`PTSC_OFF_RATIO, 32'h200);
    wr(`PTSC_OFF_CTRL, 32'h4000);
    rdchk(`PTSC_OFF_RATIO, 32'hfff, 32'h100);
    wr(`PTSC_OFF_CTRL, 32'h0);
    rdchk(`PTSC_OFF_RATIO, 32'hfff, 32'h200);
    frame(2'h0, 1'b0);
    check({omax, omin}, {10'h3ff, 10'h200});
    wr(`PTSC_OFF_RATIO, 32'h100);
    wr(`PTSC_OFF_CTRL, 32'h2);
    frame(2'h1, 1'b0);
    check({omax, omin}, {10'h300, 10'h000});
    wr(`PTSC_OFF_SHARP, 32'h0020_0000);
    frame(2'h1, 1'b0);
    check({omax, omin}, {10'h200, 10'h100});
    wr(`PTSC_OFF_SHARP, 32'h0020_00c0);
    rdchk(`PTSC_OFF_SHARP, 32'h03ff_00ff, 32'h0020_00f0);
    wr(`PTSC_OFF_SHARP, 32'h03ff_0020);
    rdchk(`PTSC_OFF_SHARP, 32'h03ff_00ff, 32'h0100_0020);
    frame(2'h1, 1'b0);
    check(omax, 10'h200);
    wr(`PTSC_OFF_SHARP, 32'h0020_0020);
    frame(2'h1, 1'b1);
    check(omax, 10'h300);
    frame(2'h1, 1'b0);
    check(omax, 10'h200);
    for (int i = 0; i < 64; i++)
      wr(`PTSC_OFF_GAMMA_TBL, (i << 16) | (1023 - 16 * i));
    wr(`PTSC_OFF_CTRL, 32'h1);
    frame(2'h1, 1'b0);
    check({omax, omin}, {10'h2ff, 10'h1ff});
    wr(`PTSC_OFF_CTRL, 32'h0);
    frame(2'h1, 1'b0);
    check({omax, omin}, {10'h200, 10'h100});
    wr(`PTSC_OFF_BLACK, 32'h55);
    rdchk(`PTSC_OFF_BLACK, 32'h3ff, 32'h55);
    wr(`PTSC_OFF_CTRL, 32'h1000);
    wr(`PTSC_OFF_BLACK, 32'h77);
    rdchk(`PTSC_OFF_BLACK, 32'h3ff, 32'h010);
    wr(`PTSC_OFF_CTRL, 32'h0930);
    i_src.frame_start();
    rdchk(`PTSC_OFF_CTRL, 32'h0f30, 32'h0800);
    wr(`PTSC_OFF_CTRL, 32'h0600);
    i_src.frame_start();
    rdchk(`PTSC_OFF_CTRL, 32'h0f00, 32'h0200);
    finish_test();
  end
endmodule
